// >>> tef_pkg.sv
// Constants and types for the timer event flag block.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package tef_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [4:0]  OFF_CTRL       = 5'h00;
	localparam logic [4:0]  OFF_IRQ_EN     = 5'h0C;
	localparam logic [4:0]  OFF_FLAGS      = 5'h10;
	localparam logic [4:0]  OFF_EVENT_GEN  = 5'h14;

	////////////////////////////////////////////////////////////////////////////////
	// Flag bit positions; bits 0 to 7 are shared with enables and event generation, over-capture bits are flags only
	localparam int          BIT_UPDATE     = 0;
	localparam int          BIT_CHAN1      = 1;
	localparam int          BIT_CHAN2      = 2;
	localparam int          BIT_COMMUT     = 5;
	localparam int          BIT_TRIGGER    = 6;
	localparam int          BIT_BREAK      = 7;
	localparam int          BIT_OVCAP1     = 9;
	localparam int          BIT_OVCAP2     = 10;

	// Interrupt enable register: DMA enable positions
	localparam int          BIT_UPD_DMA    = 8;
	localparam int          BIT_CH1_DMA    = 9;
	localparam int          BIT_CH2_DMA    = 10;
	localparam int          BIT_TRG_DMA    = 14;

	// Control register fields
	localparam int          BIT_UPD_DIS    = 0;
	localparam int          BIT_UPD_SRC    = 1;
	localparam int          BIT_CH1_INPUT  = 2;
	localparam int          BIT_CH2_INPUT  = 3;

	////////////////////////////////////////////////////////////////////////////////
	// Implemented-bit masks and reset values
	localparam logic [15:0] FLAGS_MASK     = 16'h06E7;
	localparam logic [15:0] IRQ_SRC_MASK   = 16'h00E7;
	localparam logic [15:0] IRQ_EN_MASK    = 16'h47E7;
	localparam logic [15:0] CTRL_MASK      = 16'h000F;
	localparam logic [15:0] EVENT_GEN_MASK = 16'h00E7;
	localparam logic [15:0] FLAGS_RESET    = 16'h0000;
	localparam logic [15:0] IRQ_EN_RESET   = 16'h0000;
	localparam logic [15:0] CTRL_RESET     = 16'h0000;
	localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;
	localparam logic [15:0] ZERO16         = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// Bus handshake state
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ACK  = 2'b01
	} tef_bus_state_t;

endpackage

// >>> tef_top.sv
// Status flags, interrupt enables and event generation of a dual channel timer.
// Assumes event strobes from the counter core are one cycle wide and synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module tef_top
	import tef_pkg::*;
#(
	parameter int CNT_W  = 16,
	parameter int ADDR_W = 5
) (
	// Clock, reset and enable
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              ce,
	// Avalon-MM slave
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	input  wire logic [3:0]        byteenable,
	output logic      [31:0]       readdata,
	output logic                   waitrequest,
	// Counter core events
	input  wire logic [CNT_W-1:0]  counter_value,
	input  wire logic              count_tick,
	input  wire logic              repetition_wrap,
	input  wire logic              trigger_reinit,
	input  wire logic              trigger_event,
	input  wire logic              commutation_event,
	input  wire logic              break_active,
	// Capture/compare channels
	input  wire logic [CNT_W-1:0]  chan1_compare_capture_value,
	input  wire logic [CNT_W-1:0]  chan2_compare_capture_value,
	input  wire logic              chan1_capture,
	input  wire logic              chan2_capture,
	input  wire logic              chan1_capture_read,
	input  wire logic              chan2_capture_read,
	// Event pulses to the core
	output logic                   update_event,
	output logic                   chan1_generate,
	output logic                   chan2_generate,
	output logic                   commutation_generate,
	output logic                   trigger_generate,
	output logic                   break_generate,
	// Interrupt and DMA requests
	output logic                   irq,
	output logic                   update_dma_req,
	output logic                   chan1_dma_req,
	output logic                   chan2_dma_req,
	output logic                   trigger_dma_req
);

	////////////////////////////////////////////////////////////////////////////////
	// Parameter checks

	if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt_w
		$error("CNT_W must be between 1 and 32");
	end
	if (ADDR_W < 5 || ADDR_W > 16) begin : g_bad_addr_w
		$error("ADDR_W must be between 5 and 16");
	end
	if (BIT_OVCAP2 > 15 || BIT_TRG_DMA > 15) begin : g_bad_bit_pos
		$error("Flag and enable positions must fit in 16 bits");
	end
	if ((FLAGS_RESET & ~FLAGS_MASK) != ZERO16) begin : g_bad_flag_reset
		$error("Flag reset value must only use implemented bits");
	end

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		// Bus handshake
		tef_bus_state_t bus;
		logic           waitreq;
		logic [31:0]    rdata;

		// Software registers and flags
		logic [15:0]    ctrl;
		logic [15:0]    irq_en;
		logic [15:0]    flags;

		// Pulses and requests
		logic           upd_pulse;
		logic [15:0]    gen_pulse;
		logic           irq;
		logic [3:0]     dma;
	} tef_state_t;

	tef_state_t s_reg;
	tef_state_t s_next;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Bits of the low half-word that the active byte lanes cover
	function automatic logic [15:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[1]}}, {8{be[0]}}};
	endfunction

	// Address compare on the low byte-address bits, with all upper address bits zero
	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [4:0] off);
		addr_is = (a[4:0] == off) && ((a >> 5) == '0);
	endfunction

	// Byte-lane merge of a register write, keeping only implemented bits
	function automatic logic [15:0] merge_write(input logic [15:0] old_v, input logic [15:0] new_v,
		input logic [15:0] lanes, input logic [15:0] impl);
		merge_write = ((old_v & ~lanes) | (new_v & lanes)) & impl;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Decoded access and event terms

	// Bus access
	logic        hit_ctrl;
	logic        hit_irq_en;
	logic        hit_flags;
	logic        hit_gen;
	logic        wr_ack;
	logic [15:0] wmask;
	logic [15:0] wdata16;
	logic        wr_ctrl;
	logic        wr_irq_en;
	logic        wr_flags;
	logic        wr_gen;
	logic [15:0] gen_bits;

	// Configuration
	logic        upd_dis;
	logic        upd_src;
	logic        ch1_in;
	logic        ch2_in;

	// Event terms
	logic        upd_wrap;
	logic        upd_gen;
	logic        upd_trig;
	logic        upd_ev;
	logic        match1;
	logic        match2;
	logic        cap1;
	logic        cap2;
	logic        ovcap1;
	logic        ovcap2;
	logic        cap_rd1;
	logic        cap_rd2;

	// Flag and read paths
	logic [15:0] set_bits;
	logic [15:0] clr_bits;
	logic [15:0] flags_new;
	logic [31:0] rd_word;

	always_comb begin
		hit_ctrl   = addr_is(address, OFF_CTRL);
		hit_irq_en = addr_is(address, OFF_IRQ_EN);
		hit_flags  = addr_is(address, OFF_FLAGS);
		hit_gen    = addr_is(address, OFF_EVENT_GEN);
		wr_ack     = (s_reg.bus == BUS_ACK) && write && !read;
		wmask      = lane_mask(byteenable);
		wdata16    = writedata[15:0];
		wr_ctrl    = wr_ack && hit_ctrl;
		wr_irq_en  = wr_ack && hit_irq_en;
		wr_flags   = wr_ack && hit_flags;
		wr_gen     = wr_ack && hit_gen;
		gen_bits   = wr_gen ? (wdata16 & wmask & EVENT_GEN_MASK) : ZERO16;

		upd_dis   = s_reg.ctrl[BIT_UPD_DIS];
		upd_src   = s_reg.ctrl[BIT_UPD_SRC];
		ch1_in    = s_reg.ctrl[BIT_CH1_INPUT];
		ch2_in    = s_reg.ctrl[BIT_CH2_INPUT];

		// Update event sources
		upd_wrap = repetition_wrap && !upd_dis;
		upd_gen  = gen_bits[BIT_UPDATE] && !upd_dis && !upd_src;
		upd_trig = trigger_reinit && !upd_dis && !upd_src;
		upd_ev   = upd_wrap || upd_gen || upd_trig;

		// Compare match counts only on a counter step
		match1 = !ch1_in && count_tick && (counter_value == chan1_compare_capture_value);
		match2 = !ch2_in && count_tick && (counter_value == chan2_compare_capture_value);
		// Captures and capture-register reads only count in input mode
		cap1    = ch1_in && chan1_capture;
		cap2    = ch2_in && chan2_capture;
		cap_rd1 = ch1_in && chan1_capture_read;
		cap_rd2 = ch2_in && chan2_capture_read;

		// Over-capture looks at the flag before this cycle's clear
		ovcap1 = ch1_in && (chan1_capture || gen_bits[BIT_CHAN1]) && s_reg.flags[BIT_CHAN1];
		ovcap2 = ch2_in && (chan2_capture || gen_bits[BIT_CHAN2]) && s_reg.flags[BIT_CHAN2];

		set_bits              = ZERO16;
		set_bits[BIT_UPDATE]  = upd_ev;
		set_bits[BIT_CHAN1]   = match1 || cap1 || gen_bits[BIT_CHAN1];
		set_bits[BIT_CHAN2]   = match2 || cap2 || gen_bits[BIT_CHAN2];
		set_bits[BIT_COMMUT]  = commutation_event || gen_bits[BIT_COMMUT];
		set_bits[BIT_TRIGGER] = trigger_event || gen_bits[BIT_TRIGGER];
		// Break flag follows the live level, so a clear cannot win while it is high
		set_bits[BIT_BREAK]   = break_active || gen_bits[BIT_BREAK];
		set_bits[BIT_OVCAP1]  = ovcap1;
		set_bits[BIT_OVCAP2]  = ovcap2;

		// Writing zero clears, only in enabled byte lanes
		clr_bits = wr_flags ? (~wdata16 & wmask) : ZERO16;
		clr_bits[BIT_CHAN1] = clr_bits[BIT_CHAN1] || cap_rd1;
		clr_bits[BIT_CHAN2] = clr_bits[BIT_CHAN2] || cap_rd2;

		// Set wins over a clear in the same cycle
		flags_new = ((s_reg.flags & ~clr_bits) | set_bits) & FLAGS_MASK;

		// Read multiplexer; unmapped addresses and reserved bits read zero
		rd_word = RDATA_RESET;
		if (hit_ctrl) begin
			rd_word[15:0] = s_reg.ctrl & CTRL_MASK;
		end else if (hit_irq_en) begin
			rd_word[15:0] = s_reg.irq_en & IRQ_EN_MASK;
		end else if (hit_flags) begin
			rd_word[15:0] = s_reg.flags & FLAGS_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt and DMA request terms

	logic [15:0] irq_en_new;
	logic [15:0] irq_pend;
	logic [3:0]  dma_en;
	logic [3:0]  dma_src;

	always_comb begin
		// Enables as they will stand next cycle, so requests rise with the flag
		irq_en_new = wr_irq_en ? merge_write(s_reg.irq_en, wdata16, wmask, IRQ_EN_MASK) : s_reg.irq_en;
		irq_pend   = flags_new & irq_en_new & IRQ_SRC_MASK;
		dma_en     = {irq_en_new[BIT_TRG_DMA], irq_en_new[BIT_CH2_DMA], irq_en_new[BIT_CH1_DMA], irq_en_new[BIT_UPD_DMA]};
		dma_src    = {flags_new[BIT_TRIGGER], flags_new[BIT_CHAN2], flags_new[BIT_CHAN1], flags_new[BIT_UPDATE]};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		s_next           = s_reg;
		s_next.upd_pulse = 1'b0;
		s_next.gen_pulse = ZERO16;

		// One wait cycle, then a single acknowledge cycle
		case (s_reg.bus)
			BUS_IDLE: begin
				if (read || write) begin
					s_next.bus     = BUS_ACK;
					s_next.waitreq = 1'b0;
					s_next.rdata   = read ? rd_word : RDATA_RESET;
				end
			end
			BUS_ACK: begin
				s_next.bus     = BUS_IDLE;
				s_next.waitreq = 1'b1;
			end
			default: begin
				s_next.bus     = BUS_IDLE;
				s_next.waitreq = 1'b1;
			end
		endcase

		// Configuration writes
		if (wr_ctrl) begin
			s_next.ctrl = merge_write(s_reg.ctrl, wdata16, wmask, CTRL_MASK);
		end
		s_next.irq_en = irq_en_new;

		// Flags and one-cycle event pulses
		s_next.flags     = flags_new;
		s_next.upd_pulse = upd_ev;
		s_next.gen_pulse = gen_bits;

		// Interrupt line tracks flags as they will stand next cycle
		s_next.irq = |irq_pend;
		s_next.dma = dma_en & dma_src;
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			// Bus handshake
			s_reg.bus       <= BUS_IDLE;
			s_reg.waitreq   <= 1'b1;
			s_reg.rdata     <= RDATA_RESET;

			// Software registers and flags
			s_reg.ctrl      <= CTRL_RESET;
			s_reg.irq_en    <= IRQ_EN_RESET;
			s_reg.flags     <= FLAGS_RESET;

			// Pulses and requests
			s_reg.upd_pulse <= 1'b0;
			s_reg.gen_pulse <= ZERO16;
			s_reg.irq       <= 1'b0;
			s_reg.dma       <= 4'h0;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	// Bus
	assign readdata             = s_reg.rdata;
	assign waitrequest          = s_reg.waitreq;

	// Event pulses
	assign update_event         = s_reg.upd_pulse;
	assign chan1_generate       = s_reg.gen_pulse[BIT_CHAN1];
	assign chan2_generate       = s_reg.gen_pulse[BIT_CHAN2];
	assign commutation_generate = s_reg.gen_pulse[BIT_COMMUT];
	assign trigger_generate     = s_reg.gen_pulse[BIT_TRIGGER];
	assign break_generate       = s_reg.gen_pulse[BIT_BREAK];

	// Interrupt and DMA
	assign irq                  = s_reg.irq;
	assign update_dma_req       = s_reg.dma[0];
	assign chan1_dma_req        = s_reg.dma[1];
	assign chan2_dma_req        = s_reg.dma[2];
	assign trigger_dma_req      = s_reg.dma[3];

endmodule

`default_nettype wire

// >>> tef_top_sva.sv
// Bound checker for the timer event flag block.
// Assumes one clock domain and the ports of tef_top.
`timescale 1ns/1ps
`default_nettype none
module tef_top_sva (
	// Clock, reset and bus
	input wire logic        clk, rstn, ce, read, write, waitrequest,
	input wire logic [31:0] readdata,
	// Events
	input wire logic        repetition_wrap, trigger_reinit, trigger_event,
	input wire logic        commutation_event, break_active, count_tick,
	input wire logic        chan1_capture, chan2_capture,
	input wire logic        chan1_capture_read, chan2_capture_read,
	// Outputs watched
	input wire logic        update_event, irq, trigger_dma_req, trigger_generate
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	ack_cause_a: assert property ($fell(waitrequest) |-> $past(read || write))
		else $error("ack without request");
	ack_pulse_a: assert property (!waitrequest && ce |=> waitrequest)
		else $error("ack longer than one cycle");
	rd_upper_a: assert property (!waitrequest && read |-> readdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	upd_cause_a: assert property (update_event |-> $past(repetition_wrap || trigger_reinit || write))
		else $error("update event without cause");
	irq_keep_a: assert property ($fell(irq) |-> $past(write || chan1_capture_read || chan2_capture_read))
		else $error("irq dropped without clear");
	irq_cause_a: assert property ($rose(irq) |-> $past(repetition_wrap || trigger_reinit || trigger_event
		|| commutation_event || break_active || chan1_capture || chan2_capture || count_tick || write))
		else $error("irq rose without event");
	trg_rise_a: assert property ($rose(trigger_dma_req) |-> $past(trigger_event || write))
		else $error("trigger request without event");
	trg_keep_a: assert property ($fell(trigger_dma_req) |-> $past(write))
		else $error("trigger request dropped");
	gen_pulse_a: assert property (trigger_generate |-> $past(write) ##1 !trigger_generate)
		else $error("trigger generate not a pulse");
endmodule

bind tef_top tef_top_sva i_tef_top_sva (.clk, .rstn, .ce, .read, .write, .waitrequest, .readdata,
	.repetition_wrap, .trigger_reinit, .trigger_event, .commutation_event, .break_active, .count_tick,
	.chan1_capture, .chan2_capture, .chan1_capture_read, .chan2_capture_read,
	.update_event, .irq, .trigger_dma_req, .trigger_generate);
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the timer event flag block.
// Assumes tef_pkg, tef_top and the bound checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import tef_pkg::*;
;
	logic        clk, rstn, ce, read, write, waitrequest, irq, trigger_dma_req;
	logic        repetition_wrap, trigger_reinit, trigger_event, commutation_event;
	logic        break_active, count_tick, chan1_capture, chan2_capture;
	logic        chan1_capture_read, chan2_capture_read;
	logic [4:0]  address;
	logic [3:0]  byteenable;
	logic [31:0] writedata, readdata;
	logic [15:0] counter_value, chan1_compare_capture_value, chan2_compare_capture_value;
	logic [15:0] ef, q, v;
	logic        update_event, chan1_generate, chan2_generate, commutation_generate, trigger_generate;
	logic        break_generate, update_dma_req, chan1_dma_req, chan2_dma_req;
	int          err_total, num_checks, seed, npulse, p0;

	tef_top i_tef_top (.clk, .rstn, .ce, .address, .read, .write, .writedata, .byteenable,
		.readdata, .waitrequest, .counter_value, .count_tick, .repetition_wrap, .trigger_reinit,
		.trigger_event, .commutation_event, .break_active, .chan1_compare_capture_value,
		.chan2_compare_capture_value, .chan1_capture, .chan2_capture, .chan1_capture_read,
		.chan2_capture_read, .update_event, .chan1_generate, .chan2_generate,
		.commutation_generate, .trigger_generate, .break_generate, .irq,
		.update_dma_req, .chan1_dma_req, .chan2_dma_req, .trigger_dma_req);

	// Adds, each cycle, the number of event pulse outputs that stand high
	always @(posedge clk) begin
		if (!rstn) npulse <= 0;
		else npulse <= npulse + update_event + chan1_generate + chan2_generate + commutation_generate
			+ trigger_generate + break_generate;
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] ebit(input int k);
		return (k < 2) ? 16'h0001 : (k == 2) ? 16'h0040 : 16'h0020;
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		writedata <= {16'h0000, d};
		read <= !w;
		write <= w;
		do @(posedge clk); while (waitrequest !== 1'b0 && ++n < 50);
		if (n >= 50) err_total++;
		q = readdata[15:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		bus(1'b0, a, 16'h0000);
		chk(q, e);
	endtask
	task automatic pulse(input int k);
		@(posedge clk);
		case (k)
			0: repetition_wrap <= 1'b1;
			1: trigger_reinit <= 1'b1;
			2: trigger_event <= 1'b1;
			3: commutation_event <= 1'b1;
			4: chan1_capture <= 1'b1;
			5: chan2_capture <= 1'b1;
			6: chan1_capture_read <= 1'b1;
			7: chan2_capture_read <= 1'b1;
			default: count_tick <= 1'b1;
		endcase
		@(posedge clk);
		{repetition_wrap, trigger_reinit, trigger_event, commutation_event, chan1_capture,
			chan2_capture, chan1_capture_read, chan2_capture_read, count_tick} <= '0;
		@(posedge clk);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200000;
		err_total++;
		end_sim;
	end
	initial begin
		{rstn, read, write, repetition_wrap, trigger_reinit, trigger_event, commutation_event,
			break_active, count_tick, chan1_capture, chan2_capture, chan1_capture_read,
			chan2_capture_read, address, writedata} = '0;
		{counter_value, chan1_compare_capture_value, chan2_compare_capture_value} = '0;
		ce = 1'b1;
		byteenable = 4'hF;
		seed = 26;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		chk({15'h0000, irq}, 16'h0000);
		rd(OFF_FLAGS, FLAGS_RESET);
		bus(1'b1, OFF_IRQ_EN, IRQ_SRC_MASK);
		ef = 16'h0000;
		// Wrap, re-init, trigger and commutation events, each then a random partial clear
		for (int k = 0; k < 4; k++) begin
			pulse(k);
			ef |= ebit(k);
			chk({15'h0000, irq}, 16'h0001);
			rd(OFF_FLAGS, ef);
			v = 16'($random(seed));
			bus(1'b1, OFF_FLAGS, v);
			ef &= v;
			rd(OFF_FLAGS, ef);
		end
		bus(1'b1, OFF_FLAGS, ZERO16);
		p0 = npulse;
		bus(1'b1, OFF_EVENT_GEN, EVENT_GEN_MASK);
		rd(OFF_FLAGS, 16'h00E7);
		chk(16'(npulse - p0), 16'h0006);
		bus(1'b1, OFF_IRQ_EN, IRQ_EN_MASK);
		@(posedge clk);
		chk({12'h000, trigger_dma_req, chan2_dma_req, chan1_dma_req, update_dma_req}, 16'h000F);
		bus(1'b1, OFF_FLAGS, ZERO16);
		@(posedge clk);
		chk({12'h000, trigger_dma_req, chan2_dma_req, chan1_dma_req, update_dma_req}, 16'h0000);
		bus(1'b1, OFF_CTRL, 16'h0001);
		p0 = npulse;
		pulse(0);
		pulse(1);
		rd(OFF_FLAGS, ZERO16);
		chk(16'(npulse - p0), ZERO16);
		p0 = npulse;
		bus(1'b1, OFF_CTRL, 16'h0002);
		pulse(1);
		rd(OFF_FLAGS, ZERO16);
		pulse(0);
		rd(OFF_FLAGS, 16'h0001);
		chk(16'(npulse - p0), 16'h0001);
		bus(1'b1, OFF_CTRL, ZERO16);
		bus(1'b1, OFF_FLAGS, ZERO16);
		v = 16'($random(seed));
		counter_value <= v;
		chan1_compare_capture_value <= v + 16'h0001;
		chan2_compare_capture_value <= v;
		pulse(8);
		rd(OFF_FLAGS, 16'h0004);
		chan1_compare_capture_value <= v;
		pulse(8);
		rd(OFF_FLAGS, 16'h0006);
		// Input mode on both channels
		bus(1'b1, OFF_CTRL, 16'h000C);
		bus(1'b1, OFF_FLAGS, ZERO16);
		pulse(8);
		rd(OFF_FLAGS, ZERO16);
		ef = 16'h0000;
		for (int c = 0; c < 2; c++) begin
			pulse(4 + c);
			ef |= 16'h0002 << c;
			rd(OFF_FLAGS, ef);
			pulse(4 + c);
			ef |= 16'h0200 << c;
			rd(OFF_FLAGS, ef);
			pulse(6 + c);
			ef &= ~(16'h0002 << c);
			rd(OFF_FLAGS, ef);
		end
		chk({15'h0000, irq}, 16'h0000);
		bus(1'b1, OFF_IRQ_EN, ZERO16);
		pulse(2);
		chk({15'h0000, irq}, 16'h0000);
		bus(1'b1, OFF_IRQ_EN, 16'h4040);
		@(posedge clk);
		chk({15'h0000, irq}, 16'h0001);
		chk({15'h0000, trigger_dma_req}, 16'h0001);
		bus(1'b1, OFF_FLAGS, ZERO16);
		bus(1'b1, OFF_IRQ_EN, 16'h0080);
		break_active <= 1'b1;
		bus(1'b1, OFF_FLAGS, ZERO16);
		rd(OFF_FLAGS, 16'h0080);
		break_active <= 1'b0;
		@(posedge clk);
		chk({15'h0000, irq}, 16'h0001);
		bus(1'b1, OFF_FLAGS, ZERO16);
		rd(OFF_FLAGS, ZERO16);
		rd(5'h1C, ZERO16);
		end_sim;
	end
endmodule
`default_nettype wire
